// ==== mcu_io_timer_instr_decode.v ====
`timescale 1ns/1ns
`include "decode_regs.vh"

module mcu_io_timer_instr_decode #(
  parameter TIMER_DIV = `TMR_DIV_DEF,
  parameter STACK_AW  = 3,
  parameter DMEM_AW   = 6
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output reg  [11:0] prog_addr,
  output wire        prog_req,
  input  wire [7:0]  prog_data,
  input  wire        prog_ready,
  input  wire [7:0]  bus_in,
  output reg  [7:0]  bus_out,
  output reg         bus_oe,
  output reg         bus_rd_strobe,
  output reg         bus_wr_strobe,
  input  wire [7:0]  port1_in,
  input  wire [7:0]  port2_in,
  output reg  [7:0]  port1_out,
  output reg  [7:0]  port2_out,
  input  wire [15:0] exp_in,
  output reg  [15:0] exp_out,
  input  wire        count_in,
  output wire        timer_irq
);

  localparam S_FETCH = 2'd0;
  localparam S_OPER  = 2'd1;
  localparam S_EXEC  = 2'd2;
  localparam S_HOLD  = 2'd3;

  localparam K_NOP   = 5'd0;
  localparam K_INS   = 5'd1;
  localparam K_INP   = 5'd2;
  localparam K_OUTB  = 5'd3;
  localparam K_OUTP  = 5'd4;
  localparam K_ANLB  = 5'd5;
  localparam K_ANLP  = 5'd6;
  localparam K_ORLB  = 5'd7;
  localparam K_ORLP  = 5'd8;
  localparam K_AND_NIBBLE_EXPANDER_OP  = 5'd9;
  localparam K_OR_NIBBLE_EXPANDER_OP  = 5'd10;
  localparam K_MVDI  = 5'd11;
  localparam K_MVDO  = 5'd12;
  localparam K_DEC   = 5'd13;
  localparam K_INC   = 5'd14;
  localparam K_INCI  = 5'd15;
  localparam K_CALL  = 5'd16;
  localparam K_RET   = 5'd17;
  localparam K_RETURN_RESTORE_STATUS_OP  = 5'd18;
  localparam K_TEN   = 5'd19;
  localparam K_TDIS  = 5'd20;
  localparam K_MOVAT = 5'd21;
  localparam K_MOVTA = 5'd22;
  localparam K_STOP  = 5'd23;
  localparam K_SCNT  = 5'd24;
  localparam K_STMR  = 5'd25;
  localparam K_BAD   = 5'd26;

  localparam M_STOP  = 2'd0;
  localparam M_TIMER = 2'd1;
  localparam M_EVENT = 2'd2;

  localparam [7:0] DIV_LAST = TIMER_DIV - 1;

  // one-hot-free opcode classifier; p field 00/11 on port forms is not a port
  function [4:0] op_class;
    input [7:0] op;
    begin
      op_class = K_BAD;
      if (op == 8'h00) op_class = K_NOP;
      else if (op == 8'h08) op_class = K_INS;
      else if (op[7:2] == 6'b000010 && ^op[1:0]) op_class = K_INP;
      else if (op[6:0] == 7'h02) op_class = K_OUTB;
      else if (op[7:2] == 6'b001110 && ^op[1:0]) op_class = K_OUTP;
      else if (op == 8'h98) op_class = K_ANLB;
      else if (op[7:2] == 6'b100110 && ^op[1:0]) op_class = K_ANLP;
      else if (op == 8'h88) op_class = K_ORLB;
      else if (op[7:2] == 6'b100010 && ^op[1:0]) op_class = K_ORLP;
      else if (op[7:2] == 6'b100111) op_class = K_AND_NIBBLE_EXPANDER_OP;
      else if (op[7:2] == 6'b100011) op_class = K_OR_NIBBLE_EXPANDER_OP;
      else if (op[7:2] == 6'b000011) op_class = K_MVDI;
      else if (op[7:2] == 6'b001111) op_class = K_MVDO;
      else if (op[7:3] == 5'b11001) op_class = K_DEC;
      else if (op[7:3] == 5'b00011) op_class = K_INC;
      else if (op[7:1] == 7'b0001000) op_class = K_INCI;
      else if (op[4:0] == 5'b10100) op_class = K_CALL;
      else if (op == 8'h83) op_class = K_RET;
      else if (op == 8'h93) op_class = K_RETURN_RESTORE_STATUS_OP;
      else if (op == 8'h25) op_class = K_TEN;
      else if (op == 8'h35) op_class = K_TDIS;
      else if (op == 8'h42) op_class = K_MOVAT;
      else if (op == 8'h62) op_class = K_MOVTA;
      else if (op == 8'h65) op_class = K_STOP;
      else if (op == 8'h45) op_class = K_SCNT;
      else if (op[7:3] == 5'b01010) op_class = K_STMR;
    end
  endfunction

  function two_byte;
    input [4:0] k;
    begin
      two_byte = (k == K_ANLB) || (k == K_ANLP) || (k == K_ORLB) ||
                 (k == K_ORLP) || (k == K_CALL);
    end
  endfunction

  function [1:0] cycles;
    input [4:0] k;
    begin
      if (two_byte(k) || k == K_INS || k == K_INP || k == K_AND_NIBBLE_EXPANDER_OP ||
          k == K_MVDI || k == K_RET || k == K_RETURN_RESTORE_STATUS_OP)
        cycles = `CYC_TWO;
      else
        cycles = `CYC_ONE;
    end
  endfunction

  reg  [1:0]  state_reg;
  reg  [7:0]  opcode_reg;
  reg  [7:0]  imm_reg;
  reg  [11:0] pc_reg;
  reg  [7:0]  acc_reg;
  reg  [3:0]  psw_hi_reg;
  reg  [STACK_AW-1:0] sp_reg;
  reg  [15:0] stack_reg [0:(1<<STACK_AW)-1];
  reg  [7:0]  wreg_reg [0:7];
  reg  [7:0]  dmem_reg [0:(1<<DMEM_AW)-1];
  reg  [7:0]  timer_reg;
  reg  [7:0]  div_reg;
  reg  [1:0]  mode_reg;
  reg         tien_reg;
  reg         tovf_reg;
  reg         badop_reg;
  reg         run_reg;
  reg         bank_reg;
  reg         cnt_prev_reg;
  reg  [7:0]  bus_s1, bus_s2, p1_s1, p1_s2, p2_s1, p2_s2;
  reg  [15:0] exp_s1, exp_s2;
  reg         cnt_s1, cnt_s2;
  integer     i;

  wire [4:0]  kind = op_class(opcode_reg);
  wire [1:0]  pp = opcode_reg[1:0];
  wire [2:0]  rsel = opcode_reg[2:0];
  wire [STACK_AW-1:0] sp_dec = sp_reg - 1'b1;
  wire [15:0] popped = stack_reg[sp_dec];
  wire [DMEM_AW-1:0] dm_idx = wreg_reg[{2'b00, opcode_reg[0]}][DMEM_AW-1:0];
  wire [3:0]  exp_pin = exp_s2[{pp, 2'b00} +: 4];
  wire [3:0]  exp_lat = exp_out[{pp, 2'b00} +: 4];
  wire        exec = ce && state_reg == S_EXEC;
  wire        halted = !run_reg && state_reg == S_FETCH;
  wire        apb_wr = psel && penable && pwrite && ce;
  wire        tick_t = mode_reg == M_TIMER && div_reg == DIV_LAST;
  wire        tick_e = mode_reg == M_EVENT && cnt_s2 && !cnt_prev_reg;
  wire        tmr_inc = tick_t || tick_e;
  wire        tmr_wrap = tmr_inc && timer_reg == 8'hFF;
  wire        tovf_clr = apb_wr && paddr == `A_STATUS && pwdata[`ST_TOVF];
  wire        bad_clr = apb_wr && paddr == `A_STATUS && pwdata[`ST_BADOP];

  assign pready    = ce;
  assign prog_req  = (state_reg == S_FETCH && run_reg) || state_reg == S_OPER;
  assign timer_irq = tovf_reg && tien_reg;

  // pins from outside the clock domain pass two flops first
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_s1 <= `RST_BYTE;
      bus_s2 <= `RST_BYTE;
      p1_s1  <= `RST_BYTE;
      p1_s2  <= `RST_BYTE;
      p2_s1  <= `RST_BYTE;
      p2_s2  <= `RST_BYTE;
      exp_s1 <= `RST_EXP;
      exp_s2 <= `RST_EXP;
      cnt_s1 <= 1'b0;
      cnt_s2 <= 1'b0;
    end
    else if (ce)
    begin
      bus_s1 <= bus_in;
      bus_s2 <= bus_s1;
      p1_s1  <= port1_in;
      p1_s2  <= p1_s1;
      p2_s1  <= port2_in;
      p2_s2  <= p2_s1;
      exp_s1 <= exp_in;
      exp_s2 <= exp_s1;
      cnt_s1 <= count_in;
      cnt_s2 <= cnt_s1;
    end
  end

  // sequencer: fetch opcode, optional second byte, execute, optional pad
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg  <= S_FETCH;
      opcode_reg <= `RST_BYTE;
      imm_reg    <= `RST_BYTE;
      prog_addr  <= `RST_PC;
    end
    else if (ce)
    begin
      case (state_reg)
        S_FETCH:
          if (run_reg && prog_ready)
          begin
            opcode_reg <= prog_data;
            prog_addr  <= prog_addr + 1'b1;
            state_reg  <= two_byte(op_class(prog_data)) ? S_OPER : S_EXEC;
          end
          else if (halted)
            prog_addr <= pc_reg;
        S_OPER:
          if (prog_ready)
          begin
            imm_reg   <= prog_data;
            prog_addr <= prog_addr + 1'b1;
            state_reg <= S_EXEC;
          end
        S_EXEC:
        begin
          if (kind == K_CALL)
            prog_addr <= {bank_reg, opcode_reg[7:5], imm_reg};
          else if (kind == K_RET || kind == K_RETURN_RESTORE_STATUS_OP)
            prog_addr <= popped[11:0];
          // pad a 1-byte, 2-cycle op; 2-byte ops spent their second cycle fetching
          state_reg <= (cycles(kind) == `CYC_TWO && !two_byte(kind)) ? S_HOLD : S_FETCH;
        end
        default:
          state_reg <= S_FETCH;
      endcase
    end
  end

  always @*
  begin
    pc_reg = prog_addr;
  end

  // datapath and apb-writable state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg       <= `RST_BYTE;
      psw_hi_reg    <= 4'h0;
      sp_reg        <= {STACK_AW{1'b0}};
      bus_out       <= `RST_BYTE;
      bus_oe        <= 1'b0;
      bus_rd_strobe <= 1'b0;
      bus_wr_strobe <= 1'b0;
      port1_out     <= `RST_PORT;
      port2_out     <= `RST_PORT;
      exp_out       <= `RST_EXP;
      tien_reg      <= 1'b0;
      mode_reg      <= M_STOP;
      badop_reg     <= 1'b0;
      run_reg       <= 1'b0;
      bank_reg      <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        wreg_reg[i] <= `RST_BYTE;
      for (i = 0; i < (1 << STACK_AW); i = i + 1)
        stack_reg[i] <= 16'h0000;
      for (i = 0; i < (1 << DMEM_AW); i = i + 1)
        dmem_reg[i] <= `RST_BYTE;
    end
    else if (ce)
    begin
      bus_rd_strobe <= exec && kind == K_INS;
      bus_wr_strobe <= exec && (kind == K_OUTB || kind == K_ANLB || kind == K_ORLB);
      if (apb_wr && paddr == `A_CTRL)
      begin
        run_reg  <= pwdata[`CTRL_RUN];
        bank_reg <= pwdata[`CTRL_BANK];
      end
      if (apb_wr && paddr == `A_ACC && halted)
        acc_reg <= pwdata[7:0];
      // a fresh bad opcode beats a software clear in the same cycle
      if (exec && kind == K_BAD)
        badop_reg <= 1'b1;
      else if (bad_clr)
        badop_reg <= 1'b0;
      // status upper nibble only moves on the restoring return
      if (exec)
      begin
        case (kind)
          K_INS: acc_reg <= bus_s2;
          K_INP: acc_reg <= pp[0] ? p1_s2 : p2_s2;
          K_OUTB:
          begin
            bus_out <= acc_reg;
            bus_oe  <= 1'b1;
          end
          K_OUTP:
            if (pp[0]) port1_out <= acc_reg;
            else port2_out <= acc_reg;
          K_ANLB:
          begin
            bus_out <= bus_out & imm_reg;
            bus_oe  <= 1'b1;
          end
          K_ANLP:
            if (pp[0]) port1_out <= port1_out & imm_reg;
            else port2_out <= port2_out & imm_reg;
          K_ORLB:
          begin
            bus_out <= bus_out | imm_reg;
            bus_oe  <= 1'b1;
          end
          K_ORLP:
            if (pp[0]) port1_out <= port1_out | imm_reg;
            else port2_out <= port2_out | imm_reg;
          K_AND_NIBBLE_EXPANDER_OP: exp_out[{pp, 2'b00} +: 4] <= exp_lat & acc_reg[3:0];
          K_OR_NIBBLE_EXPANDER_OP: exp_out[{pp, 2'b00} +: 4] <= exp_lat | acc_reg[3:0];
          K_MVDI: acc_reg <= {4'h0, exp_pin};
          K_MVDO: exp_out[{pp, 2'b00} +: 4] <= acc_reg[3:0];
          K_DEC: wreg_reg[rsel] <= wreg_reg[rsel] - 1'b1;
          K_INC: wreg_reg[rsel] <= wreg_reg[rsel] + 1'b1;
          K_INCI: dmem_reg[dm_idx] <= dmem_reg[dm_idx] + 1'b1;
          K_CALL:
          begin
            stack_reg[sp_reg] <= {psw_hi_reg, prog_addr};
            sp_reg <= sp_reg + 1'b1;
          end
          K_RET: sp_reg <= sp_dec;
          K_RETURN_RESTORE_STATUS_OP:
          begin
            sp_reg     <= sp_dec;
            psw_hi_reg <= popped[15:12];
          end
          K_TEN: tien_reg <= 1'b1;
          K_TDIS: tien_reg <= 1'b0;
          K_MOVAT: acc_reg <= timer_reg;
          K_STOP: mode_reg <= M_STOP;
          K_SCNT: mode_reg <= M_EVENT;
          K_STMR: mode_reg <= M_TIMER;
          default: bus_oe <= bus_oe;
        endcase
      end
      else if (state_reg == S_HOLD && kind == K_INS)
        bus_oe <= 1'b0;
    end
  end

  // timer: a load from the accumulator beats a tick in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_reg    <= `RST_BYTE;
      div_reg      <= `RST_BYTE;
      tovf_reg     <= 1'b0;
      cnt_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      cnt_prev_reg <= cnt_s2;
      if (mode_reg != M_TIMER || div_reg == DIV_LAST)
        div_reg <= `RST_BYTE;
      else
        div_reg <= div_reg + 1'b1;
      if (exec && kind == K_MOVTA)
        timer_reg <= acc_reg;
      else if (tmr_inc)
        timer_reg <= timer_reg + 1'b1;
      if (tmr_wrap && !(exec && kind == K_MOVTA))
        tovf_reg <= 1'b1;
      else if (tovf_clr)
        tovf_reg <= 1'b0;
    end
  end

  // apb read data captured in setup so the access phase shows flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce && psel && !penable)
    begin
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (paddr == `A_CTRL)
        prdata <= {30'h0, bank_reg, run_reg};
      else if (paddr == `A_STATUS)
        prdata <= {26'h0, mode_reg, tien_reg, tovf_reg, badop_reg,
                   state_reg != S_FETCH};
      else if (paddr == `A_PC)
        prdata <= {20'h0, prog_addr};
      else if (paddr == `A_ACC)
        prdata <= {24'h0, acc_reg};
      else if (paddr == `A_PSW)
        prdata <= {24'h0, psw_hi_reg, 1'b1, {(3-STACK_AW){1'b0}}, sp_reg};
      else if (paddr == `A_TIMER)
        prdata <= {24'h0, timer_reg};
      else if (paddr == `A_PORTS)
        prdata <= {8'h0, port2_out, port1_out, bus_out};
      else if (paddr == `A_EXP)
        prdata <= {16'h0, exp_out};
      else if (paddr == `A_OPCODE)
        prdata <= {24'h0, opcode_reg};
      else
        pslverr <= 1'b1;
    end
  end

endmodule // mcu_io_timer_instr_decode

// ==== decode_regs.vh ====
`ifndef DECODE_REGS_VH
`define DECODE_REGS_VH
// apb register byte offsets
`define A_CTRL    8'h00
`define A_STATUS  8'h04
`define A_PC      8'h08
`define A_ACC     8'h0C
`define A_PSW     8'h10
`define A_TIMER   8'h14
`define A_PORTS   8'h18
`define A_EXP     8'h1C
`define A_OPCODE  8'h20
// ctrl fields
`define CTRL_RUN  0
`define CTRL_BANK 1
// status fields
`define ST_BUSY   0
`define ST_BADOP  1
`define ST_TOVF   2
`define ST_TIEN   3
`define ST_MODE   4
// reset values
`define RST_PC    12'h000
`define RST_BYTE  8'h00
`define RST_PORT  8'hFF
`define RST_EXP   16'h0000
// machine cycles per instruction
`define CYC_ONE   1
`define CYC_TWO   2
// default timer prescale, in pclk cycles per timer tick
`define TMR_DIV_DEF 32
`endif

// ==== prog_mem_model.sv ====
`timescale 1ns/1ns
module prog_mem_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        slow,
  input  wire [11:0] prog_addr,
  input  wire        prog_req,
  output wire [7:0]  prog_data,
  output wire        prog_ready
);
  logic [7:0] mem [0:4095];
  logic       phase_reg;
  initial
  begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn) phase_reg <= 1'b0;
    else phase_reg <= ~phase_reg;
  end
  // slow mode answers every other cycle to stretch each fetch
  assign prog_ready = ~slow | phase_reg;
  // outside a qualified read the byte is junk that changes every cycle
  assign prog_data = (prog_req && prog_ready) ? mem[prog_addr] :
                     ~mem[prog_addr] ^ {8{phase_reg}};
endmodule // prog_mem_model

// ==== mcu_io_timer_instr_decode_props.sv ====
`timescale 1ns/1ns
module decode_props (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [11:0] prog_addr,
  input wire        prog_req,
  input wire        prog_ready,
  input wire        bus_oe,
  input wire        bus_rd_strobe,
  input wire        bus_wr_strobe,
  input wire [7:0]  port1_out,
  input wire [7:0]  port2_out,
  input wire [15:0] exp_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable && ce;
  ready_follows_ce_a:
    assert property (pready == ce) else $error("pready differs from ce");
  unmapped_err_a:
    assert property (setup && paddr > 8'h20 |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
  mapped_ok_a:
    assert property (setup && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
  fetch_hold_a:
    assert property (prog_req && !prog_ready && ce |=> $stable(prog_addr))
      else $error("fetch address moved while waiting");
  rd_pulse_a:
    assert property ($rose(bus_rd_strobe) |=> !bus_rd_strobe)
      else $error("read strobe longer than one cycle");
  wr_pulse_a:
    assert property ($rose(bus_wr_strobe) |=> !bus_wr_strobe)
      else $error("write strobe longer than one cycle");
  wr_drives_a:
    assert property (bus_wr_strobe |-> bus_oe) else $error("bus strobed while not driven");
  oe_release_a:
    assert property ($fell(bus_oe) |-> bus_rd_strobe || $past(bus_rd_strobe))
      else $error("bus released without strobed input");
  port_after_fetch_a:
    assert property (!$stable({port1_out, port2_out, exp_out}) |->
      $past(prog_req && prog_ready, 2) || $past(psel && penable && pwrite))
      else $error("port changed without an instruction");
endmodule // decode_props
bind mcu_io_timer_instr_decode decode_props decode_props_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .prog_addr(prog_addr), .prog_req(prog_req),
  .prog_ready(prog_ready), .bus_oe(bus_oe), .bus_rd_strobe(bus_rd_strobe),
  .bus_wr_strobe(bus_wr_strobe), .port1_out(port1_out), .port2_out(port2_out),
  .exp_out(exp_out));

// ==== tb_mcu_io_timer_instr_decode.sv ====
`timescale 1ns/1ns
`include "decode_regs.vh"
module tb_mcu_io_timer_instr_decode;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        slow = 1'b0;
  logic        ce = 1'b1;
  logic        count_in = 1'b0;
  logic [31:0] rd;
  logic        er;
  wire  [31:0] prdata;
  wire         pready, pslverr, prog_req, prog_ready, bus_oe, bus_rd_strobe, bus_wr_strobe;
  wire         timer_irq;
  wire  [11:0] prog_addr;
  wire  [7:0]  prog_data, bus_out, port1_out, port2_out;
  wire  [15:0] exp_out;
  int          num_errors = 0;
  int          tests_run = 0;
  // 0x940 holds the subroutine; bank bit set in CTRL supplies address bit 11
  logic [7:0]  code [0:40] = '{8'h3A, 8'h39, 8'h02, 8'h99, 8'h0F, 8'h8A, 8'hF0, 8'h98,
    8'h3C, 8'h88, 8'h81, 8'h3D, 8'h3C, 8'h09, 8'h9C, 8'h8F, 8'h0E, 8'h62, 8'h0A, 8'h42,
    8'h02, 8'h08, 8'h3A, 8'h34, 8'h40, 8'h62, 8'h25, 8'h55, 8'h38, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h35, 8'h45};
  always #5 pclk = ~pclk;
  mcu_io_timer_instr_decode #(.TIMER_DIV(2)) mcu_io_timer_instr_decode_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_req(prog_req),
    .prog_data(prog_data), .prog_ready(prog_ready), .bus_in(8'hFF), .bus_out(bus_out),
    .bus_oe(bus_oe), .bus_rd_strobe(bus_rd_strobe), .bus_wr_strobe(bus_wr_strobe),
    .port1_in(8'h3C), .port2_in(8'hC3), .port1_out(port1_out), .port2_out(port2_out),
    .exp_in(16'h0700), .exp_out(exp_out), .count_in(count_in), .timer_irq(timer_irq));
  prog_mem_model prog_mem_model_inst (
    .pclk(pclk), .presetn(presetn), .slow(slow), .prog_addr(prog_addr),
    .prog_req(prog_req), .prog_data(prog_data), .prog_ready(prog_ready));
  task automatic end_sim;
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic fail(input string name);
    num_errors++;
    $display("MISMATCH %s expected done seen timeout", name);
    end_sim();
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20) fail("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded waits sample on the falling edge, after the design has settled
  task automatic wait_pc(input logic [11:0] a);
    for (int n = 0; n < 400 && prog_addr !== a; n++) @(negedge pclk);
    if (prog_addr !== a) fail("prog_addr");
    repeat (2) @(negedge pclk);
  endtask
  task automatic wait_irq(input logic v);
    for (int n = 0; n < 400 && timer_irq !== v; n++) @(negedge pclk);
    if (timer_irq !== v) fail("timer_irq");
  endtask
  task automatic t_regs;
    apb(`A_PORTS, 1'b0, 32'h0);
    chk("ports", 32'h00FFFF00, rd);
    apb(`A_ACC, 1'b1, 32'h5A);
    apb(`A_ACC, 1'b0, 32'h0);
    chk("acc", 32'h5A, rd);
    apb(`A_PC, 1'b1, 32'h123);
    apb(`A_PC, 1'b0, 32'h0);
    chk("pc", 32'h0, rd);
    apb(8'h24, 1'b0, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("err_data", 32'h0, rd);
  endtask
  task automatic t_io;
    for (int i = 0; i < 41; i++) prog_mem_model_inst.mem[i] = code[i];
    prog_mem_model_inst.mem[12'h940] = 8'h39;
    prog_mem_model_inst.mem[12'h941] = 8'h83;
    apb(`A_CTRL, 1'b1, 32'h3);
    wait_pc(12'h00D);
    chk("port1", 32'h0A, {24'h0, port1_out});
    chk("port2", 32'hFA, {24'h0, port2_out});
    chk("bus", 32'h99, {24'h0, bus_out});
    chk("bus_oe", 32'h1, {31'h0, bus_oe});
    chk("exp", 32'h00AA, {16'h0, exp_out});
    @(posedge pclk);
    slow <= 1'b1;
    wait_pc(12'h015);
    chk("bus", 32'h07, {24'h0, bus_out});
    chk("exp", 32'hC0A8, {16'h0, exp_out});
    wait_pc(12'h940);
    wait_pc(12'h019);
    chk("port1", 32'hFF, {24'h0, port1_out});
    chk("port2", 32'hFF, {24'h0, port2_out});
    chk("bus_oe", 32'h0, {31'h0, bus_oe});
  endtask
  task automatic t_timer;
    wait_irq(1'b1);
    wait_irq(1'b0);
    wait_pc(12'h02C);
    apb(`A_CTRL, 1'b1, 32'h0);
    apb(`A_STATUS, 1'b0, 32'h0);
    chk("status", 32'h13, {27'h0, rd[5:1]});
    apb(`A_PSW, 1'b0, 32'h0);
    chk("psw", 32'h08, rd);
    apb(`A_ACC, 1'b0, 32'h0);
    chk("acc", 32'hFF, rd);
    apb(`A_STATUS, 1'b1, 32'h6);
    apb(`A_STATUS, 1'b0, 32'h0);
    chk("status_clr", 32'h0, {30'h0, rd[2:1]});
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_io();
    t_timer();
    end_sim();
  end
endmodule // tb_mcu_io_timer_instr_decode
